// ===== dv/ipv_seq_model.sv
// Instruction sequencer stand-in framing instructions on machine cycles
`timescale 1ns/100ps
module ipv_seq_model (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Machine cycle end from the unit
  input  wire logic         cycleEnd,
  // Next instruction chosen by the bench
  input  wire logic [2:0]   nextLen,
  input  wire logic         nextRet,
  input  wire logic         nextWr,
  // Status towards the unit
  output ipv_pkg::ipv_seq_t seqStat
);
  import ipv_pkg::*;
  logic [2:0] left_ff;
  ipv_seq_t   kind_ff;
  always_ff @(posedge mclk) begin
    if (reset) begin
      left_ff <= 3'h0;
      kind_ff <= '0;
    end else if (cycleEnd && left_ff == 3'h0) begin
      left_ff <= nextLen - 3'h1;
      kind_ff <= '{lastCycle: 1'b0, statusWrite: nextWr, retIntr: nextRet};
    end else if (cycleEnd) begin
      left_ff <= left_ff - 3'h1;
    end
  end
  // Final cycle stays flagged all cycle; up to eight cycles per instruction (a nextLen of 0 gives eight)
  always_comb begin
    seqStat = kind_ff;
    seqStat.lastCycle = (left_ff == 3'h0);
  end
endmodule : ipv_seq_model

// ===== dv/tb_top.sv
// Self-checking bench for the interrupt poll and vector unit
`timescale 1ns/100ps
module tb_top;
  import ipv_pkg::*;
  logic [NUM_SRC-1:0] reqFlags = '0, srcEnable = '0, srcPrioHigh = '0, flagClr, clrSeen = '0;
  logic mclk = 1'b0, reset = 1'b1, nextRet = 1'b0, nextWr = 1'b0, prevAct = 1'b0, cycleEnd;
  logic ce = 1'b1;
  logic [2:0] nextLen = 3'h1;
  logic [1:0] inProgress;
  logic [3:0] phaseTick;
  logic [31:0] rnd = 32'h0000_0bda;
  ipv_seq_t seqStat;
  ipv_call_t callOut;
  int mismatches = 0;
  int cmp_count = 0;
  logic [16:0] expQ[$];
  always #2 mclk = ~mclk;
  ipv_interrupt_poll_vector_unit u_dut (.mclk(mclk), .reset(reset), .ce(ce),
    .reqFlags(reqFlags), .srcEnable(srcEnable), .srcPrioHigh(srcPrioHigh), .seqStat(seqStat),
    .callOut(callOut), .flagClr(flagClr), .inProgress(inProgress), .phaseTick(phaseTick),
    .cycleEnd(cycleEnd));
  ipv_seq_model u_seq (.mclk(mclk), .reset(reset), .cycleEnd(cycleEnd), .nextLen(nextLen),
    .nextRet(nextRet), .nextWr(nextWr), .seqStat(seqStat));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s;
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xorshift
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task automatic close_out();
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic waitCall(output int n);
    n = 0;
    while (callOut.active !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
  endtask : waitCall
  // Flags stay up through the call so the in-progress level must hold them off
  task automatic endCall(input logic [1:0] ipExp);
    int n;
    n = 0;
    while (callOut.active === 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check(n == 24, "call length");
    check(inProgress === ipExp, "in progress level");
    @(posedge mclk);
    reqFlags <= '0;
    nextRet <= 1'b1;
    n = 0;
    while (inProgress !== 2'b00 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    nextRet <= 1'b0;
    check(inProgress === 2'b00, "return clear");
  endtask : endCall
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    prevAct <= callOut.active;
    // The clear pulse stands at the first edge that sees the call up
    clrSeen <= (callOut.active === 1'b1 && prevAct === 1'b0) ? flagClr : clrSeen | flagClr;
    if (!reset && callOut.active === 1'b1 && prevAct === 1'b0) begin
      if (expQ.size() == 0) check(1'b0, "unexpected call");
      else check({callOut.level, callOut.vector} === expQ.pop_front(), "vector");
    end
  end
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    int n;
    int idx;
    logic hi;
    logic [3:0] hold;
    repeat (16) @(posedge mclk);
    check(callOut === '0 && inProgress === 2'h0 && phaseTick === 4'h0, "reset state");
    reset <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      rnd = xorshift(rnd);
      idx = (k == 0) ? 31 : (k == 1) ? 0 : int'(rnd[4:0]);
      hi = rnd[7];
      @(posedge mclk);
      nextLen <= 3'h1 + {1'b0, rnd[9:8]};
      srcEnable <= rnd | (32'h1 << idx);
      srcPrioHigh <= 32'(hi) << idx;
      expQ.push_back({hi, VEC_BASE + 16'(idx * 8)});
      reqFlags <= 32'h1 << idx;
      waitCall(n);
      check(n + 24 > 36 && n + 24 < 108, "latency");
      endCall(hi ? 2'b10 : 2'b01);
      check(clrSeen === (HW_CLEAR_MASK & (32'h1 << idx)), "flag clear");
    end
    $display("vector test done");
    // Low source 5 waits behind high 9 and 12, then vanishes before return
    @(posedge mclk);
    srcEnable <= '1;
    srcPrioHigh <= 32'h0000_1200;
    expQ.push_back({1'b1, VEC_BASE + 16'h0048});
    reqFlags <= 32'h0000_1220;
    waitCall(n);
    endCall(2'b10);
    $display("priority test done");
    // Flush any longer instruction so every running one is a status write
    @(posedge mclk);
    nextWr <= 1'b1;
    nextLen <= 3'h1;
    srcPrioHigh <= '0;
    repeat (60) @(posedge mclk);
    reqFlags <= 32'h0000_0100;
    repeat (24) @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    hold = phaseTick;
    repeat (4) @(posedge mclk);
    check(phaseTick === hold, "clock enable freeze");
    ce <= 1'b1;
    repeat (24) @(posedge mclk);
    expQ.push_back({1'b0, VEC_BASE + 16'h0040});
    nextWr <= 1'b0;
    waitCall(n);
    check(n < 100, "write delay");
    endCall(2'b01);
    $display("write block test done");
    close_out();
  end
endmodule : tb_top

// ===== src/interrupt_poll_vector_unit.sv
// Interrupt sampling, polling, priority blocking and hardware call sequencing
`timescale 1ns/100ps
module ipv_interrupt_poll_vector_unit (
  // Clock, reset, enable
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic                        ce,
  // Request sources and their enable/priority settings
  input  wire logic [ipv_pkg::NUM_SRC-1:0] reqFlags,
  input  wire logic [ipv_pkg::NUM_SRC-1:0] srcEnable,
  input  wire logic [ipv_pkg::NUM_SRC-1:0] srcPrioHigh,
  // Instruction sequencer status
  input  wire ipv_pkg::ipv_seq_t           seqStat,
  // Call request towards the sequencer, flag clears, in-progress levels and cycle timing
  output ipv_pkg::ipv_call_t               callOut,
  output logic [ipv_pkg::NUM_SRC-1:0]      flagClr,
  output logic [1:0]                       inProgress,
  output logic [3:0]                       phaseTick,
  output logic                             cycleEnd
);
  import ipv_pkg::*;

  logic [3:0]         phase_ff;
  logic [NUM_SRC-1:0] sample_ff;
  logic [NUM_SRC-1:0] poll_ff;
  logic               callAct_ff;
  logic               callCnt_ff;
  logic [15:0]        callVec_ff;
  logic               callLvl_ff;
  logic [1:0]         inProg_ff;
  logic [NUM_SRC-1:0] flagClr_ff;

  logic               mcEnd;
  logic               effLast;
  logic               effSpecial;
  logic [NUM_SRC-1:0] pendHi;
  logic [NUM_SRC-1:0] pendLo;
  logic               pickValid;
  logic               pickLevel;
  logic [SRC_W-1:0]   pickIdx;
  logic               decide;
  logic [15:0]        pickVec;

  function automatic logic [SRC_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [SRC_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = SRC_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle timing
  always_ff @(posedge mclk) begin
    if (reset) begin
      phase_ff <= 4'h0;
    end else if (ce) begin
      phase_ff <= (phase_ff == PH_LAST) ? 4'h0 : phase_ff + 4'h1;
    end
  end

  assign mcEnd     = ce && (phase_ff == PH_LAST);
  assign phaseTick = phase_ff;
  assign cycleEnd  = mcEnd;

  ////////////////////////////////////////////////////////////////////////////
  // Sampling and polling
  // Disabled sources never reach the poll, so an enable change lands one cycle late
  always_ff @(posedge mclk) begin
    if (reset) begin
      sample_ff <= FLAGS_RST;
    end else if (ce && phase_ff == PH_S5P2) begin
      sample_ff <= reqFlags & srcEnable;
    end
  end

  // Overwritten every cycle: a request not taken now leaves no trace
  always_ff @(posedge mclk) begin
    if (reset) begin
      poll_ff <= FLAGS_RST;
    end else if (mcEnd) begin
      poll_ff <= sample_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decision
  // The hardware call behaves as a two-cycle instruction, so a poll during its
  // last cycle may redirect it before any handler opcode runs
  assign effLast    = callAct_ff ? callCnt_ff : seqStat.lastCycle;
  assign effSpecial = callAct_ff ? 1'b0 : (seqStat.statusWrite || seqStat.retIntr);

  assign pendHi = poll_ff & srcPrioHigh;
  assign pendLo = poll_ff & ~srcPrioHigh;

  always_comb begin
    pickValid = 1'b0;
    pickLevel = 1'b0;
    pickIdx   = '0;
    if (|pendHi && !inProg_ff[1]) begin
      pickValid = 1'b1;
      pickLevel = 1'b1;
      pickIdx   = first_set(pendHi);
    end else if (|pendLo && inProg_ff == 2'b00) begin
      pickValid = 1'b1;
      pickIdx   = first_set(pendLo);
    end
  end

  assign pickVec = VEC_BASE + (16'(pickIdx) << VEC_STEP_SHIFT);
  assign decide  = mcEnd && pickValid && effLast && !effSpecial;

  ////////////////////////////////////////////////////////////////////////////
  // Hardware call sequencing
  always_ff @(posedge mclk) begin
    if (reset) begin
      callAct_ff <= 1'b0;
      callCnt_ff <= 1'b0;
      callVec_ff <= VEC_RST;
      callLvl_ff <= 1'b0;
    end else if (decide) begin
      callAct_ff <= 1'b1;
      callCnt_ff <= 1'b0;
      callVec_ff <= pickVec;
      callLvl_ff <= pickLevel;
    end else if (mcEnd && callAct_ff) begin
      callCnt_ff <= ~callCnt_ff;
      callAct_ff <= ~callCnt_ff;
    end
  end

  assign callOut.active = callAct_ff;
  assign callOut.vector = callVec_ff;
  assign callOut.level  = callLvl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // In-progress levels
  // A plain subroutine return is not seen here, so the level stays set
  always_ff @(posedge mclk) begin
    if (reset) begin
      inProg_ff <= 2'b00;
    end else if (decide) begin
      inProg_ff[pickLevel] <= 1'b1;
    end else if (mcEnd && !callAct_ff && seqStat.retIntr && seqStat.lastCycle) begin
      if (inProg_ff[1]) begin
        inProg_ff[1] <= 1'b0;
      end else begin
        inProg_ff[0] <= 1'b0;
      end
    end
  end

  assign inProgress = inProg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Flag clear on vectoring
  always_ff @(posedge mclk) begin
    if (reset) begin
      flagClr_ff <= FLAGS_RST;
    end else if (ce) begin
      flagClr_ff <= decide ? (HW_CLEAR_MASK & (NUM_SRC'(1) << pickIdx)) : FLAGS_RST;
    end
  end

  assign flagClr = flagClr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !ce);

  phase_wrap_a: assert property (phase_ff == PH_LAST |=> phase_ff == 4'h0)
    else $error("machine cycle did not wrap after state 6 phase 2");
  vec_range_a: assert property (callAct_ff |-> callVec_ff[2:0] == 3'b011 && callVec_ff <= VEC_MAX)
    else $error("call vector off the eight byte grid");
  sample_time_a: assert property (phase_ff == PH_S5P2 |=> sample_ff == $past(reqFlags & srcEnable))
    else $error("flags not captured at state 5 phase 2");
  poll_copy_a: assert property (mcEnd |=> poll_ff == $past(sample_ff))
    else $error("poll does not use previous cycle sample");
  call_start_a: assert property (decide |=> callAct_ff && callVec_ff == $past(pickVec))
    else $error("decision did not start the call");
  prio_block_a: assert property (decide |-> !inProg_ff[1] && (pickLevel || !inProg_ff[0]))
    else $error("call issued under equal or higher level");
  final_cycle_a: assert property (decide && !callAct_ff |-> seqStat.lastCycle)
    else $error("call decided mid instruction");
  status_hold_a: assert property (mcEnd && !callAct_ff && (seqStat.retIntr || seqStat.statusWrite)
                                  |-> !decide)
    else $error("call decided after return or status write");
  call_len_a: assert property ($rose(callAct_ff) |-> callAct_ff [*8] ##1 callAct_ff [*8]
                               ##1 callAct_ff [*8])
    else $error("call shorter than two machine cycles");
  return_from_interrupt_clear_a: assert property (mcEnd && !callAct_ff && seqStat.retIntr && seqStat.lastCycle
                                 && inProg_ff[1] |=> !inProg_ff[1])
    else $error("return from interrupt left level set");
  flag_clr_a: assert property (|flagClr_ff |-> $past(decide) && (flagClr_ff & ~HW_CLEAR_MASK) == '0)
    else $error("flag cleared for a software cleared source");
  hi_first_a: assert property (decide && |pendHi && !inProg_ff[1] |=> callLvl_ff)
    else $error("lower level chosen over higher");

  cov_call_c:    cover property (decide);
  cov_preempt_c: cover property (decide && callAct_ff);
  cov_nested_c:  cover property (decide && pickLevel && inProg_ff[0]);
  cov_return_from_interrupt_c:    cover property (mcEnd && seqStat.retIntr && seqStat.lastCycle && |inProg_ff);

endmodule : ipv_interrupt_poll_vector_unit

// ===== src/ipv_pkg.sv
// Constants and carrier types of the interrupt poll and vector unit
package ipv_pkg;

  localparam int          NUM_SRC        = 32;
  localparam int          SRC_W          = 5;
  localparam int          STATES_PER_MC  = 6;
  localparam int          PHASES_PER_ST  = 2;
  localparam int          CLKS_PER_PHASE = 1;
  localparam int          CLKS_PER_MC    = STATES_PER_MC * PHASES_PER_ST * CLKS_PER_PHASE;
  localparam logic [3:0]  PH_LAST        = 4'(CLKS_PER_MC - 1);
  // State 5 phase 2 is the tenth phase tick of the cycle
  localparam logic [3:0]  PH_S5P2        = 4'((4 * PHASES_PER_ST + 1) * CLKS_PER_PHASE);
  localparam logic [15:0] VEC_BASE       = 16'h0003;
  localparam int          VEC_STEP_SHIFT = 3;
  localparam logic [15:0] VEC_MAX        = 16'h00fb;
  localparam logic [1:0]  CALL_MCS       = 2'h2;
  // Sources whose request flag is cleared by the vector call itself
  localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 32'h0000_000f;
  localparam logic [NUM_SRC-1:0] FLAGS_RST     = 32'h0000_0000;
  localparam logic [15:0]        VEC_RST       = 16'h0000;

  typedef struct packed {
    logic lastCycle;
    logic statusWrite;
    logic retIntr;
  } ipv_seq_t;

  typedef struct packed {
    logic        active;
    logic [15:0] vector;
    logic        level;
  } ipv_call_t;

endpackage : ipv_pkg
